/* design/clock_select_latency_pins.sv */
`timescale 1ns/100ps

// Function
// - Down pulse lowers latency one step.
// - Up pulse raises latency one step.
// - Latency pins step only when enabled; both-high buildout strap acts regardless.
// - Disabled pins: latency from adjust word.
// - Both pins high disables phase buildout.
// - Manual pin select: 0 one, 1 two.
// - Pin select off: register bit, pin released.
// - Automatic mode shows active input on pin.
// - Both alarmed: hold last active input.
// - Indicator driven only when enabled.
// - Status bit always mirrors active input.
// - Serial clock pin clocks control port.
// - Data pin bidirectional I2C, output SPI.
// - Address bits used only in I2C.
// - Address two doubles as SPI select.
// - Data-in pin used only in SPI.
// - Protocol pin: 0 I2C, 1 SPI.
module clock_select_latency_pins
  import pin_ctrl_pkg::*;
#(
  parameter int LAT_W = pin_ctrl_pkg::LAT_WIDTH
) (
  // Clock and reset
  input  wire logic             i_ref_clk,
  input  wire logic             i_srst,
  // Latency pins and their control
  input  wire logic             i_latency_up_pin,
  input  wire logic             i_latency_down_pin,
  input  wire logic             i_latency_pin_enable,
  input  wire logic [LAT_W-1:0] i_latency_adjust_word,
  output logic      [LAT_W-1:0] o_latency_word,
  output logic                  o_latency_step_up,
  output logic                  o_latency_step_down,
  output logic                  o_buildout_disable,
  // Input clock selection
  input  wire logic             i_auto_select_mode,
  input  wire logic             i_select_pin_enable,
  input  wire logic             i_select_register_bit,
  input  wire logic             i_active_indicate_enable,
  input  wire logic             i_alarm_input_one,
  input  wire logic             i_alarm_input_two,
  output logic                  o_active_status_bit,
  output logic                  o_digital_hold,
  // Shared select or active pin
  input  wire logic             i_select_or_active_pin,
  output logic                  o_select_or_active_pin,
  output logic                  o_select_or_active_oe,
  // Serial port pins
  input  wire logic             i_serial_clock_pin,
  input  wire logic             i_serial_data_io,
  output logic                  o_serial_data_io,
  output logic                  o_serial_data_oe,
  input  wire logic             i_port_address_bit_zero,
  input  wire logic             i_port_address_bit_one,
  input  wire logic             i_address_two_or_select,
  input  wire logic             i_serial_data_in_pin,
  input  wire logic             i_control_protocol_pin,
  // Control port engine side
  input  wire logic             i_port_data_out,
  input  wire logic             i_port_data_drive,
  output logic                  o_port_clock,
  output logic                  o_port_data_in,
  output logic      [2:0]       o_port_address,
  output logic                  o_port_select_n,
  output logic                  o_protocol_is_spi
);

  typedef struct packed {
    logic             up_prev;
    logic             down_prev;
    logic             step_up;
    logic             step_down;
    logic [LAT_W-1:0] lat_count;
    logic [LAT_W-1:0] lat_word;
    logic             buildout_off;
    logic             active;
    logic             hold;
    logic             sel_out;
    logic             sel_oe;
    logic             port_clock;
    logic             data_in;
    logic [2:0]       address;
    logic             select_n;
    logic             is_spi;
    logic             sda_out;
    logic             sda_oe;
  } pin_state_t;

  pin_state_t          state_reg;
  pin_state_t          state_next;
  logic [NUM_PINS-1:0] pins_raw;
  logic [NUM_PINS-1:0] pins_sync;
  logic                up_s;
  logic                down_s;
  logic                spi_s;

  assign pins_raw[PIN_LAT_UP]       = i_latency_up_pin;
  assign pins_raw[PIN_LAT_DOWN]     = i_latency_down_pin;
  assign pins_raw[PIN_SELECT]       = i_select_or_active_pin;
  assign pins_raw[PIN_SERIAL_CLOCK] = i_serial_clock_pin;
  assign pins_raw[PIN_SERIAL_DATA]  = i_serial_data_io;
  assign pins_raw[PIN_ADDR_ZERO]    = i_port_address_bit_zero;
  assign pins_raw[PIN_ADDR_ONE]     = i_port_address_bit_one;
  assign pins_raw[PIN_ADDR_TWO]     = i_address_two_or_select;
  assign pins_raw[PIN_DATA_IN]      = i_serial_data_in_pin;
  assign pins_raw[PIN_PROTOCOL]     = i_control_protocol_pin;

  pin_sync #(
    .WIDTH (NUM_PINS)
  ) u_pin_sync (
    .i_ref_clk (i_ref_clk),
    .i_srst    (i_srst),
    .i_async   (pins_raw),
    .o_sync    (pins_sync)
  );

  assign up_s   = pins_sync[PIN_LAT_UP];
  assign down_s = pins_sync[PIN_LAT_DOWN];
  assign spi_s  = pins_sync[PIN_PROTOCOL];

  // A held-high pair is the buildout strap, never a step, so steps are
  // taken only from an edge while the other pin is low.
  function automatic logic step_edge(input logic cur, input logic prev, input logic other);
    step_edge = cur && !prev && !other;
  endfunction

  always_comb
  begin
    state_next           = state_reg;
    state_next.up_prev   = up_s;
    state_next.down_prev = down_s;

    state_next.step_up   = i_latency_pin_enable && step_edge(up_s, state_reg.up_prev, down_s);
    state_next.step_down = i_latency_pin_enable &&
                           step_edge(down_s, state_reg.down_prev, up_s);

    // increment one period
    // The counter wraps freely at LAT_W bits; there are no end stops, so the word repeats every 2^LAT_W steps.
    if (state_next.step_up)
    begin
      state_next.lat_count = state_reg.lat_count + LAT_W'(1);
    end
    else if (state_next.step_down)
    begin
      state_next.lat_count = state_reg.lat_count - LAT_W'(1);
    end

    if (i_latency_pin_enable)
    begin
      state_next.lat_word = state_next.lat_count;
    end
    else
    begin
      state_next.lat_word = i_latency_adjust_word;
    end

    state_next.buildout_off = up_s && down_s;

    state_next.hold = i_auto_select_mode && i_alarm_input_one && i_alarm_input_two;

    if (i_auto_select_mode)
    begin
      if (!state_next.hold)
      begin
        if ((state_reg.active == SEL_INPUT_ONE) && i_alarm_input_one)
        begin
          state_next.active = SEL_INPUT_TWO;
        end
        else if ((state_reg.active == SEL_INPUT_TWO) && i_alarm_input_two)
        begin
          state_next.active = SEL_INPUT_ONE;
        end
      end
      state_next.sel_oe  = i_active_indicate_enable;
      state_next.sel_out = state_next.active;
    end
    else
    begin
      if (i_select_pin_enable)
      begin
        state_next.active = pins_sync[PIN_SELECT];
      end
      else
      begin
        state_next.active = i_select_register_bit;
      end
      state_next.sel_oe  = 1'h0;
      state_next.sel_out = 1'h0;
    end

    state_next.is_spi     = spi_s;
    state_next.port_clock = pins_sync[PIN_SERIAL_CLOCK];

    if (spi_s == PROTOCOL_SPI)
    begin
      state_next.address  = ADDR_RESET;
      state_next.select_n = pins_sync[PIN_ADDR_TWO];
      state_next.data_in  = pins_sync[PIN_DATA_IN];
      state_next.sda_out  = i_port_data_out;
      state_next.sda_oe   = i_port_data_drive && !pins_sync[PIN_ADDR_TWO];
    end
    else
    begin
      state_next.address  = {pins_sync[PIN_ADDR_TWO], pins_sync[PIN_ADDR_ONE],
                             pins_sync[PIN_ADDR_ZERO]};
      state_next.select_n = 1'h1;
      state_next.data_in  = pins_sync[PIN_SERIAL_DATA];
      state_next.sda_out  = 1'h0;
      state_next.sda_oe   = i_port_data_drive && !i_port_data_out;
    end
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (i_srst)
    begin
      state_reg           <= '0;
      state_reg.lat_count <= LAT_COUNT_RESET;
      state_reg.lat_word  <= LAT_COUNT_RESET;
      state_reg.active    <= ACTIVE_RESET;
      state_reg.address   <= ADDR_RESET;
      state_reg.select_n  <= 1'h1;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  assign o_latency_word         = state_reg.lat_word;
  assign o_latency_step_up      = state_reg.step_up;
  assign o_latency_step_down    = state_reg.step_down;
  assign o_buildout_disable     = state_reg.buildout_off;
  assign o_active_status_bit    = state_reg.active;
  assign o_digital_hold         = state_reg.hold;
  assign o_select_or_active_pin = state_reg.sel_out;
  assign o_select_or_active_oe  = state_reg.sel_oe;
  assign o_serial_data_io       = state_reg.sda_out;
  assign o_serial_data_oe       = state_reg.sda_oe;
  assign o_port_clock           = state_reg.port_clock;
  assign o_port_data_in         = state_reg.data_in;
  assign o_port_address         = state_reg.address;
  assign o_port_select_n        = state_reg.select_n;
  assign o_protocol_is_spi      = state_reg.is_spi;

  default clocking cb @(posedge i_ref_clk);
  endclocking

  default disable iff (i_srst);

  sequence seq_up_rise;
    i_latency_pin_enable && up_s && !state_reg.up_prev && !down_s;
  endsequence

  sequence seq_down_rise;
    i_latency_pin_enable && down_s && !state_reg.down_prev && !up_s;
  endsequence

  sequence seq_single_up;
    o_latency_step_up ##1 !o_latency_step_up;
  endsequence

  sequence seq_single_down;
    o_latency_step_down ##1 !o_latency_step_down;
  endsequence

  a_up_single_step: assert property (seq_up_rise |=> seq_single_up)
    else $error("Up edge did not give exactly one step.");

  a_down_single_step: assert property (seq_down_rise |=> seq_single_down)
    else $error("Down edge did not give exactly one step.");

  a_count_follows_up: assert property (
    o_latency_step_up |-> state_reg.lat_count == $past(state_reg.lat_count) + LAT_W'(1))
    else $error("Latency count did not rise with an up step.");

  a_count_follows_down: assert property (
    o_latency_step_down |-> state_reg.lat_count == $past(state_reg.lat_count) - LAT_W'(1))
    else $error("Latency count did not fall with a down step.");

  a_pins_ignored_off: assert property (
    !i_latency_pin_enable |=> !o_latency_step_up && !o_latency_step_down)
    else $error("Latency step taken while pins disabled.");

  a_word_from_register: assert property (
    !i_latency_pin_enable |=> o_latency_word == $past(i_latency_adjust_word))
    else $error("Latency word not taken from adjust word.");

  a_buildout_both_high: assert property (
    (up_s && down_s) |=> o_buildout_disable && !o_latency_step_up && !o_latency_step_down)
    else $error("Both pins high did not disable buildout.");

  a_manual_pin_select: assert property (
    !i_auto_select_mode && i_select_pin_enable
    |=> o_active_status_bit == $past(pins_sync[PIN_SELECT]))
    else $error("Manual pin select not followed.");

  a_manual_pin_released: assert property (
    !i_auto_select_mode |=> !o_select_or_active_oe)
    else $error("Select pin driven in manual mode.");

  a_hold_last_active: assert property (
    i_auto_select_mode && i_alarm_input_one && i_alarm_input_two
    |=> o_digital_hold && $stable(o_active_status_bit))
    else $error("Active input changed while both alarmed.");

  a_indicator_drive: assert property (
    i_auto_select_mode |=> o_select_or_active_oe == $past(i_active_indicate_enable))
    else $error("Indicator enable not honoured.");

  a_indicator_mirror: assert property (
    o_select_or_active_oe |-> o_select_or_active_pin == o_active_status_bit)
    else $error("Indicator pin differs from status bit.");

  a_spi_address_masked: assert property (
    spi_s |=> o_port_address == ADDR_RESET && o_protocol_is_spi)
    else $error("Address bits leaked in SPI mode.");

  a_i2c_no_select: assert property (
    !spi_s |=> o_port_select_n && o_serial_data_io == 1'h0)
    else $error("SPI roles active in I2C mode.");

endmodule

/* design/pin_ctrl_pkg.sv */
package pin_ctrl_pkg;

  // Nominal size of one latency step, one internal oscillator period.
  localparam int OSC_PERIOD_PS     = 200;
  localparam int LAT_WIDTH         = 16;
  localparam int SYNC_STAGES       = 2;

  // Positions of the pins in the synchroniser vector.
  localparam int PIN_LAT_UP        = 0;
  localparam int PIN_LAT_DOWN      = 1;
  localparam int PIN_SELECT        = 2;
  localparam int PIN_SERIAL_CLOCK  = 3;
  localparam int PIN_SERIAL_DATA   = 4;
  localparam int PIN_ADDR_ZERO     = 5;
  localparam int PIN_ADDR_ONE      = 6;
  localparam int PIN_ADDR_TWO      = 7;
  localparam int PIN_DATA_IN       = 8;
  localparam int PIN_PROTOCOL      = 9;
  localparam int NUM_PINS          = 10;

  // Encodings of the pin levels.
  localparam logic SEL_INPUT_ONE   = 1'h0;
  localparam logic SEL_INPUT_TWO   = 1'h1;
  localparam logic PROTOCOL_I2C    = 1'h0;
  localparam logic PROTOCOL_SPI    = 1'h1;

  // Reset values.
  localparam logic [LAT_WIDTH-1:0] LAT_COUNT_RESET = 16'h0000;
  localparam logic [2:0]           ADDR_RESET      = 3'h0;
  localparam logic                 ACTIVE_RESET    = 1'h0;

endpackage

`timescale 1ns/100ps

module pin_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input  wire logic             i_ref_clk,
  input  wire logic             i_srst,
  // Pins
  input  wire logic [WIDTH-1:0] i_async,
  output logic      [WIDTH-1:0] o_sync
);

  typedef struct packed {
    logic [WIDTH-1:0] first;
    logic [WIDTH-1:0] second;
  } sync_state_t;

  sync_state_t state_reg;
  sync_state_t state_next;

  // The first stage feeds only the second, so metastability never reaches logic.
  always_comb
  begin
    state_next.first  = i_async;
    state_next.second = state_reg.first;
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (i_srst)
    begin
      state_reg <= '0;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  assign o_sync = state_reg.second;

endmodule

/* testbench/clock_select_latency_pins_test.sv */
`timescale 1ns/100ps

module clock_select_latency_pins_test;
  import pin_ctrl_pkg::*;
  logic i_ref_clk, i_srst, i_latency_pin_enable, i_auto_select_mode, i_select_pin_enable;
  logic i_select_register_bit, i_active_indicate_enable, i_alarm_input_one;
  logic i_alarm_input_two, i_port_address_bit_zero, i_port_address_bit_one;
  logic i_port_data_out, i_port_data_drive, sel_on, sel_drv, d, e, pc_d;
  logic o_latency_step_up, o_latency_step_down, o_buildout_disable, o_active_status_bit;
  logic o_digital_hold, o_select_or_active_pin, o_select_or_active_oe, o_serial_data_io;
  logic o_serial_data_oe, o_port_clock, o_port_data_in, o_port_select_n, o_protocol_is_spi;
  logic [LAT_WIDTH-1:0] i_latency_adjust_word, o_latency_word, w;
  logic [LAT_WIDTH-1:0] exp_q[$];
  logic [2:0]           o_port_address, a;
  int                   n_fail = 0, n_tests = 0, cyc = 0, seed, k, rises;
  wire                  up, dn, sclk, serial_data_in_pin, ss_n, mode;
  wire                  sda = o_serial_data_oe ? o_serial_data_io : 1'h1;
  wire cs = o_select_or_active_oe ? o_select_or_active_pin : (sel_on ? sel_drv : 1'h0);

  clock_select_latency_pins i_clock_select_latency_pins (
    .i_ref_clk, .i_srst, .i_latency_up_pin(up), .i_latency_down_pin(dn),
    .i_latency_pin_enable, .i_latency_adjust_word, .o_latency_word, .o_latency_step_up,
    .o_latency_step_down, .o_buildout_disable, .i_auto_select_mode, .i_select_pin_enable,
    .i_select_register_bit, .i_active_indicate_enable, .i_alarm_input_one,
    .i_alarm_input_two, .o_active_status_bit, .o_digital_hold, .i_select_or_active_pin(cs),
    .o_select_or_active_pin, .o_select_or_active_oe, .i_serial_clock_pin(sclk),
    .i_serial_data_io(sda), .o_serial_data_io, .o_serial_data_oe, .i_port_address_bit_zero,
    .i_port_address_bit_one, .i_address_two_or_select(ss_n), .i_serial_data_in_pin(serial_data_in_pin),
    .i_control_protocol_pin(mode), .i_port_data_out, .i_port_data_drive, .o_port_clock,
    .o_port_data_in, .o_port_address, .o_port_select_n, .o_protocol_is_spi
  );

  host_pins i_host_pins (.i_clk(i_ref_clk), .o_up(up), .o_down(dn), .o_sclk(sclk),
    .o_sdi(serial_data_in_pin), .o_ss_n(ss_n), .o_mode(mode));

  task automatic chk_word(input logic [LAT_WIDTH-1:0] got, input logic [LAT_WIDTH-1:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      n_fail++;
      $display("Error at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    chk_word({15'h0000, got}, {15'h0000, exp});
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge i_ref_clk);
    #1;
  endtask

  task automatic finish_test();
    $display("Comparisons %0d, mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  initial
  begin
    i_ref_clk = 1'h0;
    forever #5 i_ref_clk = ~i_ref_clk;
  end

  // A step with nothing queued is a stray step and fails on purpose.
  always @(posedge i_ref_clk)
  begin
    cyc <= cyc + 1;
    pc_d <= o_port_clock;
    if (o_port_clock === 1'h1 && pc_d === 1'h0)
      rises <= rises + 1;
    if (o_latency_step_up === 1'h1 || o_latency_step_down === 1'h1)
      chk_word(o_latency_word,
               exp_q.size() ? exp_q.pop_front() : ~o_latency_word);
    if (cyc == 6000)
    begin
      n_fail++;
      finish_test();
    end
  end

  initial
  begin
    seed = 39;
    {i_latency_pin_enable, i_auto_select_mode, i_select_pin_enable, i_select_register_bit,
     i_active_indicate_enable, i_alarm_input_one, i_alarm_input_two, i_port_address_bit_zero,
     i_port_address_bit_one, i_port_data_out, i_port_data_drive, sel_on, sel_drv} = 13'h0000;
    i_latency_adjust_word = 16'h0000;
    i_srst = 1'h1;
    repeat (6) @(posedge i_ref_clk);
    i_srst <= 1'h0;
    i_latency_pin_enable <= 1'h1;
    w = LAT_COUNT_RESET;
    for (k = 0; k < 12; k++)
    begin
      d = 1'($random(seed));
      w = d ? w + 16'h0001 : w - 16'h0001;
      exp_q.push_back(w);
      i_host_pins.pulse(d, ~d, 3);
    end
    wt(4);
    chk_word(16'(exp_q.size()), 16'h0000);
    w = 16'($random(seed));
    @(posedge i_ref_clk);
    i_latency_pin_enable <= 1'h0;
    i_latency_adjust_word <= w;
    i_host_pins.pulse(1'h1, 1'h0, 3);
    i_host_pins.pulse(1'h0, 1'h1, 3);
    wt(2);
    chk_word(o_latency_word, w);
    i_latency_pin_enable <= 1'h1;
    fork
      i_host_pins.pulse(1'h1, 1'h1, 10);
      begin
        wt(7);
        chk_bit(o_buildout_disable, 1'h1);
      end
    join
    wt(3);
    chk_bit(o_buildout_disable, 1'h0);
    for (k = 0; k < 4; k++)
    begin
      d = 1'($random(seed));
      e = 1'($random(seed));
      @(posedge i_ref_clk);
      i_select_pin_enable <= k[1];
      sel_on <= k[1];
      sel_drv <= d;
      i_select_register_bit <= e;
      wt(5);
      chk_bit(o_active_status_bit, k[1] ? d : e);
      chk_bit(o_select_or_active_oe, 1'h0);
    end
    i_select_pin_enable <= 1'h0;
    sel_on <= 1'h0;
    i_select_register_bit <= SEL_INPUT_ONE;
    wt(2);
    i_auto_select_mode <= 1'h1;
    i_active_indicate_enable <= 1'h1;
    i_alarm_input_one <= 1'h1;
    wt(3);
    chk_bit(o_active_status_bit, SEL_INPUT_TWO);
    chk_bit(cs, SEL_INPUT_TWO);
    i_alarm_input_two <= 1'h1;
    wt(3);
    chk_bit(o_digital_hold, 1'h1);
    chk_bit(o_active_status_bit, SEL_INPUT_TWO);
    i_alarm_input_one <= 1'h0;
    i_active_indicate_enable <= 1'h0;
    wt(3);
    chk_bit(o_active_status_bit, SEL_INPUT_ONE);
    chk_bit(o_select_or_active_oe, 1'h0);
    for (k = 0; k < 2; k++)
    begin
      a = 3'($random(seed));
      d = 1'($random(seed));
      e = 1'($random(seed));
      i_host_pins.set_pins(k[0], a[2], e);
      i_port_address_bit_zero <= a[0];
      i_port_address_bit_one <= a[1];
      i_port_data_drive <= 1'h1;
      i_port_data_out <= d;
      wt(6);
      chk_bit(o_protocol_is_spi, k[0]);
      chk_word({13'h0000, o_port_address}, k[0] ? 16'h0000 : {13'h0000, a});
      chk_bit(o_port_select_n, k[0] ? a[2] : 1'h1);
      chk_bit(o_port_data_in, k[0] ? e : d);
      chk_bit(o_serial_data_oe, k[0] ? ~a[2] : ~d);
      // A deselected SPI target releases the data pin, so the pull-up shows instead.
      chk_bit(sda, (k[0] && a[2]) ? 1'h1 : d);
      rises = 0;
      i_host_pins.frame(8);
      wt(5);
      chk_word(16'(rises), 16'h0008);
    end
    finish_test();
  end
endmodule

/* testbench/host_pins.sv */
`timescale 1ns/100ps

module host_pins (
  // Clock for pin timing
  input  wire logic i_clk,
  // Pins toward the device
  output logic      o_up,
  output logic      o_down,
  output logic      o_sclk,
  output logic      o_sdi,
  output logic      o_ss_n,
  output logic      o_mode
);
  initial
  begin
    {o_up, o_down, o_sclk, o_sdi, o_mode} = 5'h00;
    o_ss_n = 1'h1;
  end

  // Each pulse stays high n cycles, then low 3, which keeps the sampler from merging pulses.
  task automatic pulse(input logic up, input logic dn, input int n);
    @(posedge i_clk);
    o_up <= up;
    o_down <= dn;
    repeat (n) @(posedge i_clk);
    o_up <= 1'h0;
    o_down <= 1'h0;
    repeat (3) @(posedge i_clk);
  endtask

  task automatic set_pins(input logic m, input logic ss, input logic di);
    @(posedge i_clk);
    o_mode <= m;
    o_ss_n <= ss;
    o_sdi <= di;
  endtask

  // The link clock stands low between frames; data flips after release so stale bits show.
  task automatic frame(input int bits);
    #3 o_ss_n = 1'h0;
    repeat (bits)
    begin
      #62.5 o_sclk = 1'h1;
      #62.5 o_sclk = 1'h0;
      o_sdi = ~o_sdi;
    end
    #62.5 o_ss_n = 1'h1;
    o_sdi = ~o_sdi;
  endtask
endmodule
